// ### shared/conv_mux_pkg.sv
// Constants and types for the converter input path control block.
// Assumes the processor core reaches it over its byte-wide register port.
package conv_mux_pkg;

	// ==============================================================
	// Register offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00_E8;
	localparam logic [7:0] CFG_OFS       = 8'h00_BC;
	localparam logic [7:0] CHSEL_OFS     = 8'h00_BB;
	localparam logic [7:0] PAIR_CFG_OFS  = 8'h00_BA;
	localparam logic [7:0] PIN_SEL_OFS   = 8'h00_BD;

	// ==============================================================
	// Reset values
	localparam logic [7:0] CTRL_RST      = 8'h00_00;
	localparam logic [7:0] CFG_RST       = 8'h00_00;
	localparam logic [3:0] CHSEL_RST     = 4'h0_0;
	localparam logic [3:0] PAIR_CFG_RST  = 4'h0_0;
	localparam logic [7:0] PIN_SEL_RST   = 8'h00_00;

	// ==============================================================
	// Field positions
	localparam int ENABLE_BIT      = 7;
	localparam int GAIN_LSB        = 0;
	localparam int GAIN_W          = 3;
	localparam int LOWER_PAIR_BIT  = 0;
	localparam int UPPER_PAIR_BIT  = 1;
	localparam int HV_TWOS_BIT     = 2;
	localparam int PORT_PAIR_BIT   = 3;
	localparam int PAIR_CFG_W      = 4;
	localparam int CHSEL_W         = 4;

	// ==============================================================
	// Gain codes
	localparam logic [2:0] GAIN_X1       = 3'h0_0;
	localparam logic [2:0] GAIN_X2       = 3'h0_1;
	localparam logic [2:0] GAIN_X4       = 3'h0_2;
	localparam logic [2:0] GAIN_X8       = 3'h0_3;
	localparam logic [2:0] GAIN_X16      = 3'h0_4;
	localparam logic [2:0] GAIN_HALF     = 3'h0_6;

	// ==============================================================
	// Multiplexer sources
	typedef enum logic [3:0] {
		SRC_AIN0    = 4'b0000,
		SRC_AIN1    = 4'b0001,
		SRC_AIN2    = 4'b0010,
		SRC_AIN3    = 4'b0011,
		SRC_HV_AMP  = 4'b0100,
		SRC_AGND    = 4'b0101,
		SRC_P_EVEN  = 4'b0110,
		SRC_P_ODD   = 4'b0111,
		SRC_TEMP    = 4'b1000,
		SRC_NONE    = 4'b1111
	} src_t;

endpackage

// ### hdl/conv_mux_ctrl.sv
// Control for the converter subsystem, its gain amplifier and input selector.
// Assumes one core clock, the system reset and converter results on the same clock.
`timescale 1ns/10ps
module conv_mux_ctrl #(
	parameter int RES_W = 12
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_B,
	// Register port
	input  wire logic [7:0]        SFR_ADDR,
	input  wire logic              SFR_WR,
	input  wire logic [7:0]        SFR_WDATA,
	input  wire logic              SFR_RD,
	output logic      [7:0]        SFR_RDATA,
	// Analog control
	output logic                   CONV_POWER_EN,
	output logic      [2:0]        GAIN_SEL,
	output logic      [7:0]        PIN_SWITCH_EN,
	output logic                   EVEN_BUS_EN,
	output logic                   ODD_BUS_EN,
	output logic      [3:0]        MUX_POS_SEL,
	output logic      [3:0]        MUX_NEG_SEL,
	output logic                   CHAN_VALID,
	output logic                   DIFF_MODE,
	// Conversion results
	input  wire logic              RAW_VALID,
	input  wire logic [RES_W-1:0]  RAW_DATA,
	output logic                   RES_VALID,
	output logic      [RES_W-1:0]  RES_DATA,
	output logic                   RES_TWOS
);

	// ==============================================================
	// Registers
	logic [7:0]                      ctrl_ff;
	logic [7:0]                      cfg_ff;
	logic [conv_mux_pkg::CHSEL_W-1:0]    chsel_ff;
	logic [conv_mux_pkg::PAIR_CFG_W-1:0] pair_ff;
	logic [7:0]                      pin_ff;

	wire hit_ctrl  = (SFR_ADDR == conv_mux_pkg::CTRL_OFS);
	wire hit_cfg   = (SFR_ADDR == conv_mux_pkg::CFG_OFS);
	wire hit_chsel = (SFR_ADDR == conv_mux_pkg::CHSEL_OFS);
	wire hit_pair  = (SFR_ADDR == conv_mux_pkg::PAIR_CFG_OFS);
	wire hit_pin   = (SFR_ADDR == conv_mux_pkg::PIN_SEL_OFS);

	// Read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		hit_ctrl  ? ctrl_ff :
		hit_cfg   ? cfg_ff :
		hit_chsel ? {4'h0_0, chsel_ff} :
		hit_pair  ? {4'h0_0, pair_ff} :
		hit_pin   ? pin_ff :
		8'h00_00;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_ff  <= conv_mux_pkg::CTRL_RST;
			cfg_ff   <= conv_mux_pkg::CFG_RST;
			chsel_ff <= conv_mux_pkg::CHSEL_RST;
			pair_ff  <= conv_mux_pkg::PAIR_CFG_RST;
			pin_ff   <= conv_mux_pkg::PIN_SEL_RST;
		end else if (SFR_WR) begin
			if (hit_ctrl) ctrl_ff <= SFR_WDATA;
			if (hit_cfg) cfg_ff <= SFR_WDATA;
			if (hit_chsel) chsel_ff <= SFR_WDATA[conv_mux_pkg::CHSEL_W-1:0];
			if (hit_pair) pair_ff <= SFR_WDATA[conv_mux_pkg::PAIR_CFG_W-1:0];
			if (hit_pin) pin_ff <= SFR_WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SFR_RDATA <= 8'h00_00;
		end else if (SFR_RD) begin
			SFR_RDATA <= rd_mux;
		end
	end

	// ==============================================================
	// Channel decode
	wire lower_diff = pair_ff[conv_mux_pkg::LOWER_PAIR_BIT];
	wire upper_diff = pair_ff[conv_mux_pkg::UPPER_PAIR_BIT];
	wire hv_twos    = pair_ff[conv_mux_pkg::HV_TWOS_BIT];
	wire port_diff  = pair_ff[conv_mux_pkg::PORT_PAIR_BIT];

	logic [3:0] nxt_pos;
	logic [3:0] nxt_neg;
	logic       nxt_valid;
	logic       nxt_diff;

	// Second member of an active pair has no channel of its own
	always_comb begin
		nxt_pos   = conv_mux_pkg::SRC_NONE;
		nxt_neg   = conv_mux_pkg::SRC_AGND;
		nxt_valid = 1'b1;
		nxt_diff  = 1'b0;
		case (chsel_ff)
			4'h0_0: begin
				nxt_pos  = conv_mux_pkg::SRC_AIN0;
				nxt_neg  = lower_diff ? conv_mux_pkg::SRC_AIN1 : conv_mux_pkg::SRC_AGND;
				nxt_diff = lower_diff;
			end
			4'h0_1: begin
				nxt_pos   = conv_mux_pkg::SRC_AIN1;
				nxt_valid = !lower_diff;
			end
			4'h0_2: begin
				nxt_pos  = conv_mux_pkg::SRC_AIN2;
				nxt_neg  = upper_diff ? conv_mux_pkg::SRC_AIN3 : conv_mux_pkg::SRC_AGND;
				nxt_diff = upper_diff;
			end
			4'h0_3: begin
				nxt_pos   = conv_mux_pkg::SRC_AIN3;
				nxt_valid = !upper_diff;
			end
			4'h0_4: begin
				nxt_pos  = conv_mux_pkg::SRC_HV_AMP;
				nxt_diff = hv_twos;
			end
			4'h0_5: begin
				nxt_pos   = conv_mux_pkg::SRC_AGND;
				nxt_valid = !hv_twos;
			end
			4'h0_6: begin
				nxt_pos  = conv_mux_pkg::SRC_P_EVEN;
				nxt_neg  = port_diff ? conv_mux_pkg::SRC_P_ODD : conv_mux_pkg::SRC_AGND;
				nxt_diff = port_diff;
			end
			4'h0_7: begin
				nxt_pos   = conv_mux_pkg::SRC_P_ODD;
				nxt_valid = !port_diff;
			end
			default: begin
				nxt_pos = conv_mux_pkg::SRC_TEMP;
			end
		endcase
		if (!nxt_valid) begin
			nxt_pos = conv_mux_pkg::SRC_NONE;
			nxt_neg = conv_mux_pkg::SRC_NONE;
		end
	end

	// ==============================================================
	// Port pin routing
	logic [3:0] even_pins;
	logic [3:0] odd_pins;

	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign even_pins[i] = pin_ff[2*i];
		assign odd_pins[i]  = pin_ff[2*i+1];
	end

	// ==============================================================
	// Analog control outputs, all registered
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CONV_POWER_EN <= 1'b0;
			GAIN_SEL      <= conv_mux_pkg::GAIN_X1;
			PIN_SWITCH_EN <= 8'h00_00;
			EVEN_BUS_EN   <= 1'b0;
			ODD_BUS_EN    <= 1'b0;
			MUX_POS_SEL   <= conv_mux_pkg::SRC_AIN0;
			MUX_NEG_SEL   <= conv_mux_pkg::SRC_AGND;
			CHAN_VALID    <= 1'b1;
			DIFF_MODE     <= 1'b0;
		end else begin
			CONV_POWER_EN <= ctrl_ff[conv_mux_pkg::ENABLE_BIT];
			GAIN_SEL      <= cfg_ff[conv_mux_pkg::GAIN_LSB +: conv_mux_pkg::GAIN_W];
			PIN_SWITCH_EN <= pin_ff;
			EVEN_BUS_EN   <= |even_pins;
			ODD_BUS_EN    <= |odd_pins;
			MUX_POS_SEL   <= nxt_pos;
			MUX_NEG_SEL   <= nxt_neg;
			CHAN_VALID    <= nxt_valid;
			DIFF_MODE     <= nxt_diff;
		end
	end

	// ==============================================================
	// Result formatting
	// Core delivers offset binary; flipping the top bit gives twos complement
	logic             nxt_res_valid;
	logic [RES_W-1:0] nxt_res_data;

	assign nxt_res_valid = RAW_VALID && CONV_POWER_EN;
	assign nxt_res_data  = DIFF_MODE ? {~RAW_DATA[RES_W-1], RAW_DATA[RES_W-2:0]}
	                                 : RAW_DATA;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RES_VALID <= 1'b0;
			RES_DATA  <= '0;
			RES_TWOS  <= 1'b0;
		end else begin
			RES_VALID <= nxt_res_valid;
			if (nxt_res_valid) begin
				RES_DATA <= nxt_res_data;
				RES_TWOS <= DIFF_MODE;
			end
		end
	end

	// ==============================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_power_follows_enable: assert property (
		##1 CONV_POWER_EN == $past(ctrl_ff[conv_mux_pkg::ENABLE_BIT]))
		else $error("converter power does not follow the enable bit");

	a_no_result_off: assert property (
		!CONV_POWER_EN |=> !RES_VALID)
		else $error("result delivered while converter is shut down");

	a_gain_follows_cfg: assert property (
		SFR_WR && hit_cfg |-> ##2 GAIN_SEL == $past(SFR_WDATA[2:0], 2))
		else $error("gain select does not follow the configuration write");

	a_pair_upper_zero: assert property (
		SFR_RD && hit_pair |=> SFR_RDATA[7:4] == 4'h0_0)
		else $error("upper pair register bits read nonzero");

	a_even_bus_or: assert property (
		##1 EVEN_BUS_EN == |$past({pin_ff[6], pin_ff[4], pin_ff[2], pin_ff[0]}))
		else $error("even bus enable is not the OR of even pins");

	a_odd_bus_or: assert property (
		##1 ODD_BUS_EN == |$past({pin_ff[7], pin_ff[5], pin_ff[3], pin_ff[1]}))
		else $error("odd bus enable is not the OR of odd pins");

	a_port_pair_neg: assert property (
		chsel_ff == 4'h0_6 && port_diff |=> MUX_NEG_SEL == conv_mux_pkg::SRC_P_ODD && DIFF_MODE)
		else $error("port pair does not take odd pins as negative input");

	a_lower_pair_neg: assert property (
		chsel_ff == 4'h0_0 |=> (MUX_NEG_SEL == conv_mux_pkg::SRC_AIN1) == $past(lower_diff))
		else $error("lower pair negative input wrong");

	a_hv_select: assert property (
		chsel_ff == 4'h0_4 |=> MUX_POS_SEL == conv_mux_pkg::SRC_HV_AMP && DIFF_MODE == $past(hv_twos))
		else $error("high voltage amplifier path not selected");

	a_twos_format: assert property (
		RAW_VALID && CONV_POWER_EN && DIFF_MODE
		|=> RES_TWOS && RES_DATA[RES_W-1] != $past(RAW_DATA[RES_W-1]))
		else $error("differential result not in twos complement");

	a_pin_switch_copy: assert property (
		##1 PIN_SWITCH_EN == $past(pin_ff))
		else $error("pin switches do not follow the pin select register");

	a_even_source: assert property (
		chsel_ff == 4'h0_6 |=> MUX_POS_SEL == conv_mux_pkg::SRC_P_EVEN)
		else $error("even port pins not routed to the positive input");

	a_pair_write_low: assert property (
		SFR_WR && hit_pair |=> pair_ff == $past(SFR_WDATA[3:0]))
		else $error("pair register does not keep the low write bits");

	a_port_single: assert property (
		chsel_ff == 4'h0_7 && !port_diff |=> CHAN_VALID && !DIFF_MODE)
		else $error("odd port channel not single-ended without the pair bit");

	a_upper_pair_neg: assert property (
		chsel_ff == 4'h0_2 |=> (MUX_NEG_SEL == conv_mux_pkg::SRC_AIN3) == $past(upper_diff))
		else $error("upper pair negative input wrong");

	a_pair_member_void: assert property (
		chsel_ff == 4'h0_1 && lower_diff
		|=> !CHAN_VALID && MUX_POS_SEL == conv_mux_pkg::SRC_NONE)
		else $error("second member of a lower pair still selectable");

	a_hv_single: assert property (
		chsel_ff == 4'h0_4 && !hv_twos |=> !DIFF_MODE && MUX_NEG_SEL == conv_mux_pkg::SRC_AGND)
		else $error("high voltage amplifier not single-ended with twos bit clear");

	a_result_latency: assert property (
		RAW_VALID && CONV_POWER_EN |=> RES_VALID)
		else $error("accepted result not delivered one cycle later");

	a_binary_format: assert property (
		RAW_VALID && CONV_POWER_EN && !DIFF_MODE
		|=> !RES_TWOS && RES_DATA == $past(RAW_DATA))
		else $error("single-ended result not straight binary");

endmodule

// ### tb/test_adc_input_mux_config.sv
// Self-checking bench for the converter input path control block.
// Assumes conv_mux_ctrl alone; the bench plays both core and converter.
`timescale 1ns/10ps
module test_adc_input_mux_config;
	// ==============================================================
	// Stimulus and observed signals
	logic        clk;
	logic        rst_b;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic [7:0]  sfr_wdata;
	logic        sfr_rd;
	logic        raw_valid;
	logic [11:0] raw_data;
	logic [7:0]  rd_val;
	int          n_errors;
	int          n_compared;
	int          cycles;
	wire  [7:0]  SFR_RDATA, PIN_SWITCH_EN;
	wire  [2:0]  GAIN_SEL;
	wire  [3:0]  MUX_POS_SEL, MUX_NEG_SEL;
	wire  [11:0] RES_DATA;
	wire         CONV_POWER_EN, EVEN_BUS_EN, ODD_BUS_EN, CHAN_VALID;
	wire         DIFF_MODE, RES_VALID, RES_TWOS;

	conv_mux_ctrl u_conv_mux_ctrl (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(sfr_addr),
		.SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RD(sfr_rd), .SFR_RDATA(SFR_RDATA),
		.CONV_POWER_EN(CONV_POWER_EN), .GAIN_SEL(GAIN_SEL), .PIN_SWITCH_EN(PIN_SWITCH_EN),
		.EVEN_BUS_EN(EVEN_BUS_EN), .ODD_BUS_EN(ODD_BUS_EN), .MUX_POS_SEL(MUX_POS_SEL),
		.MUX_NEG_SEL(MUX_NEG_SEL), .CHAN_VALID(CHAN_VALID), .DIFF_MODE(DIFF_MODE),
		.RAW_VALID(raw_valid), .RAW_DATA(raw_data), .RES_VALID(RES_VALID),
		.RES_DATA(RES_DATA), .RES_TWOS(RES_TWOS));

	// ==============================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			conclude();
		end
	end

	// ==============================================================
	// Shared tasks
	task automatic conclude;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		#1;
		chk("read data", e, SFR_RDATA);
	endtask
	// Register then output flop: two edges after the write edge
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic mux(input logic [3:0] p, input logic [3:0] n, input logic d);
		chk("pos source", p, MUX_POS_SEL);
		chk("neg source", n, MUX_NEG_SEL);
		chk("diff mode", d, DIFF_MODE);
	endtask
	task automatic raw(input logic [11:0] d, input logic v, input logic [11:0] e,
		input logic t);
		@(posedge clk);
		raw_valid <= 1'b1;
		raw_data <= d;
		@(posedge clk);
		raw_valid <= 1'b0;
		// Strobe stands for this one cycle only
		#1;
		chk("result strobe", v, RES_VALID);
		if (v) begin
			chk("result data", e, RES_DATA);
			chk("result twos", t, RES_TWOS);
		end
	endtask

	// ==============================================================
	// Scenarios
	task automatic t_reset;
		mux(conv_mux_pkg::SRC_AIN0, conv_mux_pkg::SRC_AGND, 1'b0);
		chk("gain", conv_mux_pkg::GAIN_X1, GAIN_SEL);
		chk("power", 1'b0, CONV_POWER_EN);
		rd(8'hBA, 8'h00);
		rd(8'hBC, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_pairs;
		wr(8'hBA, 8'hFF);
		rd(8'hBA, 8'h0F);
		rd(8'h00, 8'h00);
		wr(8'hBA, 8'h01);
		wr(8'hBB, 8'h00);
		settle();
		mux(conv_mux_pkg::SRC_AIN0, conv_mux_pkg::SRC_AIN1, 1'b1);
		wr(8'hBB, 8'h01);
		settle();
		chk("chan valid", 1'b0, CHAN_VALID);
		wr(8'hBA, 8'h02);
		wr(8'hBB, 8'h02);
		settle();
		mux(conv_mux_pkg::SRC_AIN2, conv_mux_pkg::SRC_AIN3, 1'b1);
		wr(8'hBA, 8'h00);
		wr(8'hBB, 8'h03);
		settle();
		mux(conv_mux_pkg::SRC_AIN3, conv_mux_pkg::SRC_AGND, 1'b0);
		$display("t_pairs done");
	endtask
	task automatic t_gain;
		logic [2:0] codes [6];
		codes = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h0};
		foreach (codes[i]) begin
			wr(8'hBC, {5'h00, codes[i]});
			settle();
			chk("gain", codes[i], GAIN_SEL);
		end
		$display("t_gain done");
	endtask
	task automatic t_pins;
		logic [7:0] pins [3];
		pins = '{8'h55, 8'h82, 8'hA0};
		foreach (pins[i]) begin
			wr(8'hBD, pins[i]);
			settle();
			chk("pin switches", pins[i], PIN_SWITCH_EN);
			chk("even bus", |(pins[i] & 8'h55), EVEN_BUS_EN);
			chk("odd bus", |(pins[i] & 8'hAA), ODD_BUS_EN);
		end
		$display("t_pins done");
	endtask
	task automatic t_port_pair;
		wr(8'hBD, 8'h03);
		wr(8'hBA, 8'h08);
		wr(8'hBB, 8'h06);
		settle();
		mux(conv_mux_pkg::SRC_P_EVEN, conv_mux_pkg::SRC_P_ODD, 1'b1);
		wr(8'hBA, 8'h00);
		wr(8'hBB, 8'h07);
		settle();
		mux(conv_mux_pkg::SRC_P_ODD, conv_mux_pkg::SRC_AGND, 1'b0);
		$display("t_port_pair done");
	endtask
	task automatic t_hv_result;
		wr(8'hBB, 8'h04);
		settle();
		mux(conv_mux_pkg::SRC_HV_AMP, conv_mux_pkg::SRC_AGND, 1'b0);
		raw(12'h800, 1'b0, 12'h000, 1'b0);
		wr(8'hBA, 8'h04);
		wr(8'hE8, 8'h80);
		settle();
		chk("power", 1'b1, CONV_POWER_EN);
		chk("diff mode", 1'b1, DIFF_MODE);
		raw(12'h800, 1'b1, 12'h000, 1'b1);
		wr(8'hBA, 8'h00);
		settle();
		raw(12'h123, 1'b1, 12'h123, 1'b0);
		wr(8'hE8, 8'h00);
		settle();
		chk("power", 1'b0, CONV_POWER_EN);
		$display("t_hv_result done");
	endtask
	task automatic t_sources;
		wr(8'hBA, 8'h04);
		wr(8'hBB, 8'h05);
		settle();
		chk("chan valid", 1'b0, CHAN_VALID);
		mux(conv_mux_pkg::SRC_NONE, conv_mux_pkg::SRC_NONE, 1'b0);
		wr(8'hBA, 8'h00);
		settle();
		chk("chan valid", 1'b1, CHAN_VALID);
		mux(conv_mux_pkg::SRC_AGND, conv_mux_pkg::SRC_AGND, 1'b0);
		wr(8'hBB, 8'h08);
		settle();
		mux(conv_mux_pkg::SRC_TEMP, conv_mux_pkg::SRC_AGND, 1'b0);
		wr(8'hBA, 8'h01);
		wr(8'hBB, 8'h00);
		wr(8'hE8, 8'h80);
		settle();
		raw(12'h123, 1'b1, 12'h923, 1'b1);
		wr(8'hE8, 8'h00);
		settle();
		chk("power", 1'b0, CONV_POWER_EN);
		$display("t_sources done");
	endtask

	// ==============================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_rd = 1'b0;
		raw_valid = 1'b0;
		raw_data = 12'h000;
		n_errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_pairs();
		t_gain();
		t_pins();
		t_port_pair();
		t_hv_result();
		t_sources();
		conclude();
	end
endmodule
